// file: hdl/fffd_map.svh
// Purpose: Named bit positions, codes, reset values and moduli of the feedback divider control.
// Assumes: 24-bit serial word, two address bits in the least significant positions.
// Notes: Definitions only; included by bare name.
`ifndef FFFD_MAP_SVH
`define FFFD_MAP_SVH

// ****************************************************************
// Serial word layout
// ****************************************************************
`define FFFD_SR_WIDTH 24
`define FFFD_ADDR_MSB 1
`define FFFD_ADDR_LSB 0
`define FFFD_DATA_MSB 23
`define FFFD_DATA_LSB 2
`define FFFD_ADDR_LOCK 2'h0
`define FFFD_ADDR_TIMING 2'h1
`define FFFD_ADDR_REF 2'h2
`define FFFD_ADDR_FB 2'h3
`define FFFD_TIMING_BIT 21
`define FFFD_REF_MSB 16
`define FFFD_REF_LSB 2
`define FFFD_LOCK_MSB 22
`define FFFD_LOCK_LSB 19

// ****************************************************************
// Moduli and reset values
// ****************************************************************
`define FFFD_PRESC_LO 6'h10
`define FFFD_PRESC_HI 6'h20
`define FFFD_FRAC_MOD_LO 5'h0f
`define FFFD_FRAC_MOD_HI 5'h10
`define FFFD_FB_RESET 22'h300600
`define FFFD_REF_RESET 15'h0003
`define FFFD_LOCK_RESET 4'h0
`define FFFD_TIMING_RESET 1'h0

`endif

// file: hdl/fffd_pkg.sv
// Purpose: Types shared by the feedback divider control files.
// Assumes: Field order of the structs matches the serial word data bits.
// Notes: Constants live in fffd_map.svh.
`default_nettype none
package fffd_pkg;

  typedef struct packed {
    logic counter_sync_reset;
    logic loop_power_down;
    logic prescaler_modulus_pick;
    logic [9:0] main_divide_count;
    logic [4:0] swallow_count;
    logic [3:0] fraction_numerator;
  } fffd_fb_latch_t;

  typedef struct packed {
    logic fraction_modulus_pick;
    logic [2:0] lock_pin_function;
  } fffd_lock_cfg_t;

  typedef enum logic [1:0] {PWR_ON, PWR_WAIT, PWR_DOWN} fffd_pwr_t;

endpackage : fffd_pkg
`default_nettype wire

// file: hdl/fffd_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module fffd_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    s1 <= async_in;
    s2 <= s1;
    s3 <= s2;
  end

  // A change only counts once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        rise <= s3 & ~level;
      end
    end
  end
endmodule : fffd_sync3
`default_nettype wire

// file: hdl/fffd_shift.sv
// Purpose: Serial shift register clocked by the link clock.
// Assumes: Host stops the link clock before raising the latch strobe.
// Notes: Holds data only, so it needs no reset.
`timescale 1ns/1ps
`default_nettype none
module fffd_shift #(
  parameter int WIDTH = 24
) (
  input wire logic ser_clk,
  input wire logic ser_data,
  output logic [WIDTH-1:0] word
);
  // Most significant bit arrives first and ends at the top.
  always_ff @(posedge ser_clk) begin
    word <= {word[WIDTH-2:0], ser_data};
  end
endmodule : fffd_shift
`default_nettype wire

// file: hdl/fffd_divider_ctrl.sv
// Purpose: Fractional-N feedback divider, reference counter and serially loaded latches.
// Assumes: rf_input and reference_input are slow enough to be sampled at 250 MHz.
// Notes: Pin inputs pass fffd_sync3; the shift register runs on ser_clk.
// Summary of operation
// - Counter reset bit holds feedback and reference counters in reset.
// - After counter reset release both counters restart together, within one prescaler cycle.
// - Power down disables divider and reference counter, de-biases both inputs.
// - Power down floats charge pump output and clears phase comparator.
// - Serial register keeps shifting and latching during power down.
// - Prescaler pick zero selects 16/17, one selects 32/33.
// - Timing pick one delays power down until charge pump pulse ends.
// - Timing pick zero enters power down at once.
// - Swallow count is five bits, above 15 only with 32/33.
// - Integer division is modulus times main count plus swallow count.
// - Numerator adds numerator over modulus 15 or 16 to division.
// - Reference counter is a 15-bit divider from 3 to 32767.
// - Address 00 word loads lock-output config latch at strobe rise.
// - Lock config latch keeps only modulus pick and lock function.
// - Address 11 word loads feedback divider latch at strobe rise.
// - Data sampled on serial clock rising edge, most significant bit first.
// - Modulus pick one gives modulus 16, zero gives 15.
`timescale 1ns/1ps
`default_nettype none
`include "fffd_map.svh"
module fffd_divider_ctrl #(
  parameter int SR_WIDTH = `FFFD_SR_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic rf_input,
  input wire logic reference_input,
  output logic rf_input_bias,
  output logic reference_bias,
  output logic charge_pump_up,
  output logic charge_pump_down,
  output logic charge_pump_oe,
  output logic feedback_pulse,
  output logic reference_pulse,
  output logic loop_powered_down,
  output logic fraction_modulus_pick,
  output logic [2:0] lock_pin_function
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [5:0] prescaler_base(input logic pick);
    prescaler_base = pick ? `FFFD_PRESC_HI : `FFFD_PRESC_LO;
  endfunction : prescaler_base

  function automatic logic [4:0] frac_modulus(input logic pick);
    frac_modulus = pick ? `FFFD_FRAC_MOD_HI : `FFFD_FRAC_MOD_LO;
  endfunction : frac_modulus

  function automatic logic addr_is(input logic [SR_WIDTH-1:0] w, input logic [1:0] code);
    addr_is = (w[`FFFD_ADDR_MSB:`FFFD_ADDR_LSB] == code);
  endfunction : addr_is

  // ****************************************************************
  // Serial link and pin synchronisers
  // ****************************************************************
  logic [SR_WIDTH-1:0] word;
  logic strobe_rise;
  logic rf_edge;
  logic ref_edge;

  fffd_shift #(.WIDTH(SR_WIDTH)) u_shift (
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .word(word)
  );

  fffd_sync3 u_sync_strobe (
    .clk(clk),
    .rst(rst),
    .async_in(latch_strobe),
    .level(),
    .rise(strobe_rise)
  );

  fffd_sync3 u_sync_rf (
    .clk(clk),
    .rst(rst),
    .async_in(rf_input),
    .level(),
    .rise(rf_edge)
  );

  fffd_sync3 u_sync_ref (
    .clk(clk),
    .rst(rst),
    .async_in(reference_input),
    .level(),
    .rise(ref_edge)
  );

  // ****************************************************************
  // Latches
  // ****************************************************************
  // The word is quasi-static here: the link clock is stopped while the strobe is high,
  // so sampling it a few clk cycles after the strobe edge is safe.
  fffd_pkg::fffd_fb_latch_t fb;
  fffd_pkg::fffd_lock_cfg_t lock_cfg;
  logic [14:0] ref_count;
  logic timing_pick;

  always_ff @(posedge clk) begin
    if (rst) begin
      fb <= `FFFD_FB_RESET;
    end else if (strobe_rise && addr_is(word, `FFFD_ADDR_FB)) begin
      fb <= fffd_pkg::fffd_fb_latch_t'(word[`FFFD_DATA_MSB:`FFFD_DATA_LSB]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_cfg <= `FFFD_LOCK_RESET;
    end else if (strobe_rise && addr_is(word, `FFFD_ADDR_LOCK)) begin
      lock_cfg <= word[`FFFD_LOCK_MSB:`FFFD_LOCK_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_count <= `FFFD_REF_RESET;
      timing_pick <= `FFFD_TIMING_RESET;
    end else if (strobe_rise) begin
      if (addr_is(word, `FFFD_ADDR_REF)) begin
        ref_count <= word[`FFFD_REF_MSB:`FFFD_REF_LSB];
      end
      if (addr_is(word, `FFFD_ADDR_TIMING)) begin
        timing_pick <= word[`FFFD_TIMING_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fraction_modulus_pick <= 1'b0;
      lock_pin_function <= 3'h0;
    end else begin
      fraction_modulus_pick <= lock_cfg.fraction_modulus_pick;
      lock_pin_function <= lock_cfg.lock_pin_function;
    end
  end

  // ****************************************************************
  // Power-down sequencing
  // ****************************************************************
  fffd_pkg::fffd_pwr_t pwr_state;
  logic cp_busy;
  logic pd_active;
  logic counters_hold;

  assign cp_busy = charge_pump_up | charge_pump_down;
  assign pd_active = (pwr_state == fffd_pkg::PWR_DOWN);
  assign counters_hold = fb.counter_sync_reset | pd_active;

  always_ff @(posedge clk) begin
    if (rst) begin
      // Leaving reset already powered down keeps the input biases from pulsing for one cycle.
      pwr_state <= fffd_pkg::PWR_DOWN;
    end else begin
      case (pwr_state)
        fffd_pkg::PWR_ON: begin
          if (fb.loop_power_down) begin
            pwr_state <= timing_pick ? fffd_pkg::PWR_WAIT : fffd_pkg::PWR_DOWN;
          end
        end
        fffd_pkg::PWR_WAIT: begin
          if (!fb.loop_power_down) begin
            pwr_state <= fffd_pkg::PWR_ON;
          end else if (!cp_busy) begin
            pwr_state <= fffd_pkg::PWR_DOWN;
          end
        end
        fffd_pkg::PWR_DOWN: begin
          if (!fb.loop_power_down) begin
            pwr_state <= fffd_pkg::PWR_ON;
          end
        end
        default: pwr_state <= fffd_pkg::PWR_ON;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rf_input_bias <= 1'b0;
      reference_bias <= 1'b0;
      loop_powered_down <= 1'b1;
    end else begin
      rf_input_bias <= ~pd_active;
      reference_bias <= ~pd_active;
      loop_powered_down <= pd_active;
    end
  end

  // ****************************************************************
  // Reference counter and fractional accumulator
  // ****************************************************************
  logic [14:0] ref_cnt;
  logic ref_end;
  logic [3:0] frac_acc;
  logic [4:0] frac_sum;
  logic carry_pending;

  assign ref_end = ref_edge && (ref_cnt == ref_count - 15'h0001);
  assign frac_sum = {1'b0, frac_acc} + {1'b0, fb.fraction_numerator};

  always_ff @(posedge clk) begin
    if (rst || counters_hold) begin
      ref_cnt <= 15'h0000;
    end else if (ref_edge) begin
      ref_cnt <= ref_end ? 15'h0000 : ref_cnt + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || counters_hold) begin
      frac_acc <= 4'h0;
    end else if (ref_end) begin
      if (frac_sum >= frac_modulus(lock_cfg.fraction_modulus_pick)) begin
        frac_acc <= 4'(frac_sum - frac_modulus(lock_cfg.fraction_modulus_pick));
      end else begin
        frac_acc <= frac_sum[3:0];
      end
    end
  end

  // ****************************************************************
  // Feedback divider (pulse swallow)
  // ****************************************************************
  logic [5:0] pre_cnt;
  logic [5:0] cycle_len;
  logic [4:0] swal_left;
  logic [9:0] main_left;
  logic extra;
  logic pre_end;
  logic fb_end;

  // Swallowed cycles and one fractional extra cycle each stretch a prescaler cycle by one.
  assign cycle_len = prescaler_base(fb.prescaler_modulus_pick)
                     + {5'h00, (swal_left != 5'h00)} + {5'h00, extra};
  assign pre_end = rf_edge && (pre_cnt == cycle_len - 6'h01);
  assign fb_end = pre_end && (main_left == 10'h001);

  // Overflow set wins over the consuming reload in the same cycle.
  always_ff @(posedge clk) begin
    if (rst || counters_hold) begin
      carry_pending <= 1'b0;
    end else if (ref_end && frac_sum >= frac_modulus(lock_cfg.fraction_modulus_pick)) begin
      carry_pending <= 1'b1;
    end else if (fb_end) begin
      carry_pending <= 1'b0;
    end
  end

  // Loads come only from the latch, so shifting a new word leaves the running counts alone.
  always_ff @(posedge clk) begin
    if (rst || counters_hold) begin
      pre_cnt <= 6'h00;
      swal_left <= fb.swallow_count;
      main_left <= fb.main_divide_count;
      extra <= 1'b0;
    end else if (rf_edge) begin
      if (!pre_end) begin
        pre_cnt <= pre_cnt + 6'h01;
      end else if (fb_end) begin
        pre_cnt <= 6'h00;
        swal_left <= fb.swallow_count;
        main_left <= fb.main_divide_count;
        extra <= carry_pending;
      end else begin
        pre_cnt <= 6'h00;
        extra <= 1'b0;
        main_left <= main_left - 10'h001;
        if (swal_left != 5'h00) begin
          swal_left <= swal_left - 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      feedback_pulse <= 1'b0;
      reference_pulse <= 1'b0;
    end else begin
      feedback_pulse <= fb_end & ~counters_hold;
      reference_pulse <= ref_end & ~counters_hold;
    end
  end

  // ****************************************************************
  // Phase comparator and charge pump
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || pd_active) begin
      charge_pump_up <= 1'b0;
      charge_pump_down <= 1'b0;
      charge_pump_oe <= 1'b0;
    end else begin
      charge_pump_oe <= 1'b1;
      if ((charge_pump_up | reference_pulse) && (charge_pump_down | feedback_pulse)) begin
        charge_pump_up <= 1'b0;
        charge_pump_down <= 1'b0;
      end else begin
        charge_pump_up <= charge_pump_up | reference_pulse;
        charge_pump_down <= charge_pump_down | feedback_pulse;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_hold;
    @(posedge clk) disable iff (rst)
      fb.counter_sync_reset |=> (pre_cnt == 6'h00 && ref_cnt == 15'h0000);
  endproperty
  a_hold: assert property (p_hold) else $error("counters not held in reset");

  property p_align;
    @(posedge clk) disable iff (rst)
      $fell(counters_hold) |-> (pre_cnt == 6'h00 && ref_cnt == 15'h0000 && !extra);
  endproperty
  a_align: assert property (p_align) else $error("counters misaligned at release");

  property p_debias;
    @(posedge clk) disable iff (rst) pd_active |=> (!rf_input_bias && !reference_bias);
  endproperty
  a_debias: assert property (p_debias) else $error("inputs biased in power down");

  property p_cp_float;
    @(posedge clk) disable iff (rst)
      pd_active |=> (!charge_pump_oe && !charge_pump_up && !charge_pump_down);
  endproperty
  a_cp_float: assert property (p_cp_float) else $error("charge pump active in power down");

  property p_sync_pd;
    @(posedge clk) disable iff (rst)
      (pwr_state == fffd_pkg::PWR_WAIT && cp_busy) |=> (pwr_state != fffd_pkg::PWR_DOWN);
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("power down cut a pump pulse");

  property p_async_pd;
    @(posedge clk) disable iff (rst)
      (pwr_state == fffd_pkg::PWR_ON && fb.loop_power_down && !timing_pick)
      |=> (pwr_state == fffd_pkg::PWR_DOWN);
  endproperty
  a_async_pd: assert property (p_async_pd) else $error("power down not immediate");

  property p_lock_load;
    @(posedge clk) disable iff (rst)
      (strobe_rise && addr_is(word, `FFFD_ADDR_LOCK))
      |=> (lock_cfg == $past(word[`FFFD_LOCK_MSB:`FFFD_LOCK_LSB]))
      ##2 (lock_pin_function == lock_cfg.lock_pin_function);
  endproperty
  a_lock_load: assert property (p_lock_load) else $error("lock config not loaded");

  property p_fb_stable;
    @(posedge clk) disable iff (rst) !(strobe_rise && addr_is(word, `FFFD_ADDR_FB)) |=> $stable(fb);
  endproperty
  a_fb_stable: assert property (p_fb_stable) else $error("latch changed without strobe");

  property p_modulus;
    @(posedge clk) disable iff (rst)
      (pre_end && !fb_end && swal_left == 5'h00 && !extra)
      |-> (pre_cnt == (fb.prescaler_modulus_pick ? 6'h1f : 6'h0f));
  endproperty
  a_modulus: assert property (p_modulus) else $error("wrong prescaler modulus");

  property p_carry;
    @(posedge clk) disable iff (rst || counters_hold)
      (ref_end && frac_sum >= frac_modulus(lock_cfg.fraction_modulus_pick)) |=> carry_pending;
  endproperty
  a_carry: assert property (p_carry) else $error("fraction overflow lost");

endmodule : fffd_divider_ctrl
`default_nettype wire

// file: tb/fffd_host_model.sv
// Purpose: Host side of the three-wire serial link that loads the divider latches.
// Assumes: Link clock period 125 ns, stopped low between words, phase unrelated to clk.
// Notes: The data line shows the inverse of its last bit once its hold time has run out.
`timescale 1ns/1ps
`default_nettype none
module fffd_host_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end

  // ****************************************************************
  // Word transfer
  // ****************************************************************
  task automatic send_word(input logic [23:0] word);
    #13.7;
    for (int i = 23; i >= 0; i--) begin
      ser_data <= word[i];
      #62.5 ser_clk <= 1'b1;
      #62.5 ser_clk <= 1'b0;
    end
    // The clock stays stopped so the strobe never meets a moving shift register.
    @(posedge clk);
    latch_strobe <= 1'b1;
    repeat (10) @(posedge clk);
    latch_strobe <= 1'b0;
    ser_data <= ~ser_data;
    repeat (4) @(posedge clk);
  endtask : send_word
endmodule : fffd_host_model
`default_nettype wire

// file: tb/test_fractional_feedback_divider_ctrl.sv
// Purpose: Self-checking bench for the feedback divider control block.
// Assumes: RF input toggles with a 6-cycle period, reference input with 10.
// Notes: Division checks count bench-driven RF edges between feedback pulses.
`timescale 1ns/1ps
`default_nettype none
module test_fractional_feedback_divider_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ser_clk, ser_data, latch_strobe;
  logic rf_input = 1'b0;
  logic reference_input = 1'b0;
  logic rf_input_bias, reference_bias, charge_pump_up, charge_pump_down, charge_pump_oe;
  logic feedback_pulse, reference_pulse, loop_powered_down, fraction_modulus_pick;
  logic [2:0] lock_pin_function;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h2f054311;
  int rf_rises = 0;
  int last_rises = 0;
  int skip = 0;
  int pulses = 0;
  int rf_phase = 0;
  int ref_phase = 0;
  int div_q[$];

  always #2 clk = ~clk;

  fffd_host_model host_u (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(latch_strobe));

  fffd_divider_ctrl #(.SR_WIDTH(24)) dut_u (.clk(clk), .rst(rst), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_strobe(latch_strobe), .rf_input(rf_input),
    .reference_input(reference_input), .rf_input_bias(rf_input_bias),
    .reference_bias(reference_bias), .charge_pump_up(charge_pump_up),
    .charge_pump_down(charge_pump_down), .charge_pump_oe(charge_pump_oe),
    .feedback_pulse(feedback_pulse), .reference_pulse(reference_pulse),
    .loop_powered_down(loop_powered_down), .fraction_modulus_pick(fraction_modulus_pick),
    .lock_pin_function(lock_pin_function));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check_val(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check_val

  task automatic complete_run();
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check_pwr(input logic down);
    // Sampled at the falling edge so a level launched by the last rising edge has settled.
    @(negedge clk);
    check_val("power_state", {loop_powered_down, rf_input_bias, reference_bias, charge_pump_oe},
      down ? 32'h8 : 32'h7);
    if (down) check_val("pump_idle", {charge_pump_up, charge_pump_down}, 32'h0);
  endtask : check_pwr

  task automatic expect_div(input int n, input int skips);
    int w;
    w = 0;
    skip = skips;
    div_q.push_back(n);
    while (div_q.size() > 0 && w < 30000) begin
      @(posedge clk);
      w++;
    end
    check_val("pulse_wait", div_q.size(), 32'h0);
  endtask : expect_div

  function automatic logic [23:0] fb_word(input logic cr, input logic pd, input logic p,
      input logic [9:0] m, input logic [4:0] s);
    fffd_pkg::fffd_fb_latch_t l;
    l = '{cr, pd, p, m, s, 4'h0};
    return {l, 2'h3};
  endfunction : fb_word

  // ****************************************************************
  // Pin stimulus and result monitor
  // ****************************************************************
  always @(posedge clk) begin
    rf_phase <= (rf_phase == 5) ? 0 : rf_phase + 1;
    rf_input <= (rf_phase < 3);
    rf_rises <= rf_rises + ((rf_phase == 0) ? 1 : 0);
    ref_phase <= (ref_phase == 9) ? 0 : ref_phase + 1;
    reference_input <= (ref_phase < 5);
  end

  always @(posedge clk) begin
    if (feedback_pulse === 1'b1 || reference_pulse === 1'b1) pulses <= pulses + 1;
    if (feedback_pulse === 1'b1) begin
      last_rises <= rf_rises;
      if (skip > 0) skip <= skip - 1;
      else if (div_q.size() > 0) check_val("division", rf_rises - last_rises,
        div_q.pop_front());
    end
  end

  initial begin
    #380000;
    miscompares++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [2:0] fns [4];
    logic [31:0] r;
    logic [4:0] sw;
    logic [9:0] mc;
    int n, p0, r0, w;
    fns = '{3'h0, 3'h2, 3'h6, 3'h7};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check_pwr(1'b1);
    // The host keeps every unused lock bit at zero.
    for (int i = 0; i < 4; i++) begin
      host_u.send_word({1'b0, i[0], fns[i], 17'h00000, 2'h0});
      check_val("lock_config", {fraction_modulus_pick, lock_pin_function},
        {i[0], fns[i]});
    end
    host_u.send_word(24'h000001);
    host_u.send_word(24'h00000e);
    host_u.send_word(fb_word(1'b0, 1'b0, 1'b0, 10'h003, 5'h01));
    check_pwr(1'b0);
    expect_div(49, 2);
    // Numerator 15 over modulus 16 overflows at most reference ends, so each division gains one.
    host_u.send_word(fb_word(1'b0, 1'b0, 1'b0, 10'h003, 5'h01) | 24'h00003c);
    expect_div(50, 2);
    r = $random(seed);
    sw = {1'b1, r[3:0]};
    mc = {5'h0, sw} + 10'h002 + {8'h0, r[5:4]};
    n = 32 * mc + sw;
    fork
      host_u.send_word(fb_word(1'b0, 1'b0, 1'b1, mc, sw));
      expect_div(50, 1);
    join
    expect_div(n, 2);
    host_u.send_word(fb_word(1'b1, 1'b0, 1'b1, mc, sw));
    p0 = pulses;
    repeat (600) @(posedge clk);
    check_val("held_pulses", pulses - p0, 32'h0);
    host_u.send_word(fb_word(1'b0, 1'b0, 1'b1, mc, sw));
    r0 = rf_rises;
    w = 0;
    while (feedback_pulse !== 1'b1 && w < 10000) begin
      @(posedge clk);
      w++;
    end
    check_val("restart", (rf_rises - r0 + 40 >= n) && (rf_rises - r0 <= n + 2), 32'h1);
    expect_div(n, 1);
    host_u.send_word(fb_word(1'b0, 1'b1, 1'b1, mc, sw));
    check_pwr(1'b1);
    p0 = pulses;
    repeat (600) @(posedge clk);
    check_val("down_pulses", pulses - p0, 32'h0);
    host_u.send_word(24'h200001);
    host_u.send_word(fb_word(1'b0, 1'b0, 1'b1, mc, sw));
    check_pwr(1'b0);
    host_u.send_word(fb_word(1'b0, 1'b1, 1'b1, mc, sw));
    // The pump holds its up request until the next feedback end, so entry must still wait.
    check_val("sync_wait", loop_powered_down, 32'h0);
    w = 0;
    while (loop_powered_down !== 1'b1 && w < 8000) begin
      @(posedge clk);
      w++;
    end
    check_pwr(1'b1);
    complete_run();
  end
endmodule : test_fractional_feedback_divider_ctrl
`default_nettype wire
